/* verilog/etos_pkg.sv */
/*
  etos_pkg: register map, field layout, reset values and carriers
  for the edge-triggered one-shot timer.
  assumes: AXI4-Lite slave with 32-bit data, one aligned word per register.
*/
package etos_pkg;

  // register byte offsets
  localparam logic [3:0] etos_ctrl_addr = 4'h0;
  localparam logic [3:0] etos_period_addr = 4'h4;
  localparam logic [3:0] etos_width_addr = 4'h8;
  localparam logic [3:0] etos_status_addr = 4'hc;

  // control register fields
  localparam int etos_run_bit = 0;
  localparam int etos_mode_lsb = 8;
  localparam int etos_mode_w = 5;

  // status register fields
  localparam int etos_count_lsb = 0;
  localparam int etos_armed_bit = 8;
  localparam int etos_counting_bit = 9;
  localparam int etos_drive_bit = 10;

  // trigger edge selections
  localparam logic [4:0] etos_mode_rise = 5'h09;
  localparam logic [4:0] etos_mode_fall = 5'h0a;
  localparam logic [4:0] etos_mode_both = 5'h0b;

  // reset values
  localparam logic [4:0] etos_mode_rst = 5'h09;
  localparam logic [7:0] etos_period_rst = 8'hff;
  localparam logic [7:0] etos_width_rst = 8'h00;

  localparam logic [1:0] etos_resp_okay = 2'h0;
  localparam logic [1:0] etos_resp_slverr = 2'h2;

  typedef enum logic [1:0] {
    etos_idle = 2'b00,
    etos_armed = 2'b01,
    etos_count = 2'b11
  } etos_state_t;

  typedef struct packed {
    logic [7:0] count;
    logic drive;
  } etos_out_t;

endpackage

/* verilog/etos_timer.sv */
/*
  etos_timer: edge-triggered one-shot mode of an 8-bit period timer,
  with pwm drive control and an AXI4-Lite register slave.
  assumes: one 40 MHz clock, synchronous active-low reset, trigger pin
  asynchronous to aclk, tick enable from the timer clock divider.
*/
// Register access over AXI4-Lite and the placing of the registers were decided locally.
// What this block does
// - armed timer waits for qualifying trigger edge
// - period match clears run enable bit
// - mode 01001 rise, 01010 fall, 01011 both
// - rearm after stop needs fresh trigger edge
// - starting trigger edge asserts pwm drive
// - pulse-width match deasserts pwm drive
// - drive stays off until next trigger
`timescale 1ns/1ps
`default_nettype none

module etos_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic timer_tick,
  input wire logic external_trigger_input,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [7:0] timer_count,
  output logic pwm_drive
);

  function automatic logic edge_hit(input logic [4:0] mode, input logic prev,
                                    input logic cur);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = prev & ~cur;
    unique case (mode)
      etos_pkg::etos_mode_rise: edge_hit = rise;
      etos_pkg::etos_mode_fall: edge_hit = fall;
      etos_pkg::etos_mode_both: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  // word select used by the write register decode; the read decode compares s_axi_araddr[3:2] directly
  function automatic logic word_is(input logic [3:0] addr, input logic [3:0] reg_addr);
    word_is = (addr[3:2] == reg_addr[3:2]);
  endfunction

  // trigger synchroniser; first stage read only by the second
  logic trig_meta;
  logic trig_sync;
  logic trig_prev;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      trig_prev <= 1'b0;
    end else begin
      trig_meta <= external_trigger_input;
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
    end
  end

  logic run;
  logic [4:0] mode;
  logic [7:0] period_match_value;
  logic [7:0] pulse_width_compare_value;
  etos_pkg::etos_state_t state;
  etos_pkg::etos_out_t outs;

  logic trig_edge;
  logic period_hit;
  logic width_hit;
  assign trig_edge = edge_hit(mode, trig_prev, trig_sync);
  assign period_hit = (state == etos_pkg::etos_count) && timer_tick
                      && (outs.count == period_match_value);
  assign width_hit = (state == etos_pkg::etos_count) && timer_tick
                     && (outs.count == pulse_width_compare_value);

  // write channel: address and data taken independently
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  // ready drops for the cycle after a handshake, so one beat is never taken twice
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // every word of the 4-bit space is mapped; the error answer stays as a guard
  logic sel_ctrl;
  logic sel_period;
  logic sel_width;
  logic sel_status;
  logic wr_mapped;
  assign sel_ctrl = word_is(aw_addr, etos_pkg::etos_ctrl_addr);
  assign sel_period = word_is(aw_addr, etos_pkg::etos_period_addr);
  assign sel_width = word_is(aw_addr, etos_pkg::etos_width_addr);
  assign sel_status = word_is(aw_addr, etos_pkg::etos_status_addr);
  assign wr_mapped = sel_ctrl || sel_period || sel_width || sel_status;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= etos_pkg::etos_resp_okay;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? etos_pkg::etos_resp_okay : etos_pkg::etos_resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic ctrl_wr;
  assign ctrl_wr = wr_go && sel_ctrl;

  // run enable: hardware clear at period match wins over a software set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run <= 1'b0;
    end else if (period_hit) begin
      run <= 1'b0;
    end else if (ctrl_wr && w_strb[0]) begin
      run <= w_data[etos_pkg::etos_run_bit];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= etos_pkg::etos_mode_rst;
      period_match_value <= etos_pkg::etos_period_rst;
      pulse_width_compare_value <= etos_pkg::etos_width_rst;
    end else if (wr_go) begin
      if (ctrl_wr && w_strb[1]) begin
        mode <= w_data[etos_pkg::etos_mode_lsb +: etos_pkg::etos_mode_w];
      end
      // byte 0 carries run, period and width; byte 1 the mode
      if (sel_period && w_strb[0]) begin
        period_match_value <= w_data[7:0];
      end
      if (sel_width && w_strb[0]) begin
        pulse_width_compare_value <= w_data[7:0];
      end
    end
  end

  // sequencer; any loss of run returns to idle, so rearming needs a new edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= etos_pkg::etos_idle;
    end else if (!run) begin
      state <= etos_pkg::etos_idle;
    end else begin
      unique case (state)
        etos_pkg::etos_idle: state <= etos_pkg::etos_armed;
        etos_pkg::etos_armed: begin
          if (trig_edge) begin
            state <= etos_pkg::etos_count;
          end
        end
        etos_pkg::etos_count: begin
          if (period_hit) begin
            state <= etos_pkg::etos_idle;
          end
        end
        default: state <= etos_pkg::etos_idle;
      endcase
    end
  end

  // counter holds its value when stopped by software, zero after a shot
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      outs.count <= 8'h00;
    end else if (period_hit) begin
      outs.count <= 8'h00;
    end else if (state == etos_pkg::etos_armed && run && trig_edge) begin
      outs.count <= 8'h00;
    end else if (state == etos_pkg::etos_count && run && timer_tick) begin
      outs.count <= outs.count + 8'h01;
    end
  end

  // pwm drive: on at trigger, off at width match, held off at period halt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      outs.drive <= 1'b0;
    end else if (state == etos_pkg::etos_armed && run && trig_edge) begin
      outs.drive <= 1'b1;
    end else if (width_hit) begin
      outs.drive <= 1'b0;
    end else if (period_hit) begin
      outs.drive <= 1'b0;
    end
  end

  assign timer_count = outs.count;
  assign pwm_drive = outs.drive;

  // read channel
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_word = 32'h0;
    rd_ok = 1'b1;
    unique case (s_axi_araddr[3:2])
      etos_pkg::etos_ctrl_addr[3:2]: begin
        rd_word[etos_pkg::etos_run_bit] = run;
        rd_word[etos_pkg::etos_mode_lsb +: etos_pkg::etos_mode_w] = mode;
      end
      etos_pkg::etos_period_addr[3:2]: rd_word[7:0] = period_match_value;
      etos_pkg::etos_width_addr[3:2]: rd_word[7:0] = pulse_width_compare_value;
      etos_pkg::etos_status_addr[3:2]: begin
        rd_word[etos_pkg::etos_count_lsb +: 8] = outs.count;
        rd_word[etos_pkg::etos_armed_bit] = (state == etos_pkg::etos_armed);
        rd_word[etos_pkg::etos_counting_bit] = (state == etos_pkg::etos_count);
        rd_word[etos_pkg::etos_drive_bit] = outs.drive;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= etos_pkg::etos_resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? etos_pkg::etos_resp_okay : etos_pkg::etos_resp_slverr;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

`default_nettype wire

/* test/etos_trig_src.sv */
/* etos_trig_src: trigger pin source for the one-shot timer.
   assumes: level_req moves after a rising aclk edge. */
`timescale 1ns/1ps
`default_nettype none
module etos_trig_src (
  input wire logic aclk,
  input wire logic level_req,
  input wire logic [2:0] lag,
  output logic external_trigger_input
);
  // lag gives a prompt or a slow source
  logic [7:0] pipe = 8'h00;
  always @(posedge aclk) pipe <= {pipe[6:0], level_req};
  assign external_trigger_input = pipe[lag];
endmodule
`default_nettype wire

/* test/etos_timer_props.sv */
/* etos_timer_props: port checker for etos_timer.
   assumes: bound to etos_timer, one aclk domain. */
`timescale 1ns/1ps
`default_nettype none
module etos_timer_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic timer_tick,
  input wire logic external_trigger_input,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [7:0] timer_count,
  input wire logic pwm_drive
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_count_tick: assert property (
    $changed(timer_count) && timer_count != 8'h00 |-> $past(timer_tick)) else $error("no tick");
  chk_count_step: assert property (
    $changed(timer_count) && timer_count != 8'h00 |-> timer_count == $past(timer_count) + 8'h01)
    else $error("count skipped");
  chk_count_clear: assert property (
    $changed(timer_count) && timer_count == 8'h00 |-> $past(timer_tick) || pwm_drive)
    else $error("count cleared early");
  chk_drive_start: assert property (
    $rose(pwm_drive) |-> timer_count == 8'h00) else $error("drive rose mid count");
  // two sync flops plus the edge flop: the pin step shows three and four samples back
  chk_drive_trigger: assert property (
    $rose(pwm_drive) |-> $past(external_trigger_input, 3) != $past(external_trigger_input, 4))
    else $error("drive rose without pin edge");
  chk_drive_end: assert property (
    $fell(pwm_drive) |-> $past(timer_tick)) else $error("drive fell without tick");
  chk_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read data");
  chk_wr_single: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("response repeated");
endmodule
bind etos_timer etos_timer_props u_props (.aclk, .aresetn, .timer_tick, .external_trigger_input,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .timer_count,
  .pwm_drive);
`default_nettype wire

/* test/tb.sv */
/* tb: self-checking bench for etos_timer.
   assumes: etos_pkg compiled first, checker bound in its own file. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic timer_tick = 1'b0;
  logic level_req = 1'b0;
  logic [2:0] lag = 3'h0;
  logic pin, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pwm_drive;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'hcb431846;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, was_hi = 1'b0;
  logic [7:0] timer_count;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [8:0] ticks = 9'h0;
  logic [31:0] rd_q[$];
  logic [8:0] pulse_q[$];
  int err_count = 0;
  int n_checks = 0;
  always #12.5 aclk = ~aclk;
  etos_timer DUT (.aclk, .aresetn, .timer_tick, .external_trigger_input(pin), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_count,
    .pwm_drive);
  etos_trig_src u_src (.aclk, .level_req, .lag, .external_trigger_input(pin));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic fail(input string m);
    $display("[ERR] %0t %s", $time, m);
    err_count++;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  // long enough for the slowest source lag plus the pin flops
  task automatic set_pin(input logic v);
    @(posedge aclk);
    level_req <= v;
    repeat (12) @(posedge aclk);
  endtask
  always @(posedge aclk) timer_tick <= rnd() > 32'h7fffffff;
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
      n_checks++;
      if (rd_q.size() == 0 || s_axi_rdata !== rd_q.pop_front()) fail("read data");
      if (s_axi_rresp !== etos_pkg::etos_resp_okay) fail("read response");
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
      n_checks++;
      if (s_axi_bresp !== etos_pkg::etos_resp_okay) fail("write response");
    end
    if (was_hi && pwm_drive !== 1'b1) begin
      n_checks++;
      if (pulse_q.size() == 0 || ticks !== pulse_q.pop_front()) fail("pulse length");
    end
    if (pwm_drive === 1'b1) ticks = ticks + 9'(timer_tick);
    else ticks = 9'h0;
    was_hi = pwm_drive === 1'b1;
  end
  initial begin
    #200000;
    fail("timeout");
    tally_and_finish();
  end
  initial begin
    logic [4:0] m;
    logic [7:0] p, w;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_rd(4'h0, 32'h0900);
    axi_rd(4'h4, 32'h00ff);
    axi_rd(4'h8, 32'h0000);
    for (int i = 0; i < 3; i++) begin
      m = i == 0 ? etos_pkg::etos_mode_rise : i == 1 ? etos_pkg::etos_mode_fall
        : etos_pkg::etos_mode_both;
      p = 8'h20 | 8'(rnd() & 32'h1f);
      w = 8'(rnd() & 32'h3f);
      lag <= 3'(rnd());
      set_pin(m == etos_pkg::etos_mode_rise);
      axi_wr(4'h4, 32'(p));
      axi_wr(4'h8, 32'(w));
      axi_wr(4'h0, 32'({m, 8'h01}));
      if (m != etos_pkg::etos_mode_both) set_pin(m == etos_pkg::etos_mode_fall);
      pulse_q.push_back(9'(w < p ? w : p) + 9'h1);
      set_pin(m != etos_pkg::etos_mode_fall);
      wait (pwm_drive === 1'b0 && timer_count === 8'h00);
      axi_rd(4'h0, 32'({m, 8'h00}));
    end
    set_pin(1'b0);
    axi_wr(4'h4, 32'h00c8);
    axi_wr(4'h8, 32'h0000);
    axi_wr(4'h0, 32'h0901);
    pulse_q.push_back(9'h001);
    set_pin(1'b1);
    // stop only after the drive is off, so the held drive cannot smear the pulse count
    wait (pwm_drive === 1'b0);
    axi_wr(4'h0, 32'h0900);
    axi_wr(4'h0, 32'h0901);
    // ample time for a wrongly resumed count to reach the period
    repeat (800) @(posedge aclk);
    axi_rd(4'h0, 32'h0901);
    set_pin(1'b0);
    pulse_q.push_back(9'h001);
    set_pin(1'b1);
    wait (pwm_drive === 1'b0 && timer_count === 8'h00);
    axi_rd(4'h0, 32'h0900);
    axi_rd(4'hc, 32'h0000);
    // a code outside the three edge selections never starts a shot
    axi_wr(4'h0, 32'h0c01);
    set_pin(1'b0);
    set_pin(1'b1);
    axi_rd(4'hc, 32'h0100);
    repeat (4) @(posedge aclk);
    tally_and_finish();
  end
endmodule
`default_nettype wire
